// File: design/uetc_top.sv
// endpoint transaction controller: avalon registers, banked fifos, sie sequencing
`timescale 1ns/1ps
`include "uetc_defs.svh"
module uetc_top
    import uetc_pkg::*;
#(
    parameter int NUM_EP = 4,
    parameter int DEPTH = 8,
    parameter int EPW = $clog2(NUM_EP),
    parameter int PW = $clog2(DEPTH)
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic usb_bus_reset,
    input wire uetc_sie_rx_t sie_rx,
    output uetc_sie_tx_t sie_tx,
    output logic usb_irq
);
    localparam logic [PW:0] DEPF = (PW + 1)'(DEPTH);
    localparam logic [7:0] DEP8 = 8'(DEPTH);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0] cfg_r [NUM_EP];
    logic [1:0] rxf_r [NUM_EP];
    logic [1:0] txr_r [NUM_EP];
    logic setup_r [NUM_EP];
    logic txc_r [NUM_EP];
    logic crc_r [NUM_EP];
    logic dir_r [NUM_EP];
    logic fwb_r [NUM_EP];
    logic hwb_r [NUM_EP];
    logic [7:0] cnt_r [NUM_EP][2];
    logic [PW:0] fptr_r [NUM_EP];
    logic [7:0] mem_r [NUM_EP][2][DEPTH];
    logic [NUM_EP-1:0] ien_r;
    logic [NUM_EP-1:0] flag_v;
    logic [EPW-1:0] sel_r;

    uetc_state_t st_r;
    logic [EPW-1:0] cur_ep_r;
    logic cur_bank_r;
    logic [7:0] wptr_r;
    logic [7:0] tptr_r;
    logic [7:0] tlen_r;
    logic drop_r;
    logic iso_r;
    logic stok_r;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic go_wr;
    logic go_rd;
    logic w_sta;
    logic f_wr;
    logic f_rd;
    logic [7:0] wd;
    logic [7:0] sta_v;
    logic [7:0] rd_v;

    // commit at the edge that sees waitrequest low
    assign go_wr = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign go_rd = avs_read && !avs_waitrequest;
    assign wd = avs_writedata[7:0];
    assign w_sta = go_wr && avs_address == `UETC_A_STA;
    assign f_wr = go_wr && avs_address == `UETC_A_FIFO;
    assign f_rd = go_rd && avs_address == `UETC_A_FIFO;

    always_comb begin
        sta_v = 8'h00;
        sta_v[`UETC_STA_TXC] = txc_r[sel_r];
        sta_v[`UETC_STA_RB0] = rxf_r[sel_r][0];
        sta_v[`UETC_STA_SET] = setup_r[sel_r];
        sta_v[`UETC_STA_CRC] = crc_r[sel_r];
        sta_v[`UETC_STA_TXR] = txr_r[sel_r][fwb_r[sel_r]];
        sta_v[`UETC_STA_RB1] = rxf_r[sel_r][1];
        sta_v[`UETC_STA_DIR] = dir_r[sel_r];
    end

    // every per-endpoint view follows the select register
    always_comb begin
        rd_v = 8'h00;
        case (avs_address)
            `UETC_A_SEL: rd_v = 8'(sel_r);
            `UETC_A_CFG: rd_v = cfg_r[sel_r];
            `UETC_A_STA: rd_v = sta_v;
            `UETC_A_FIFO: begin
                if (fptr_r[sel_r] < DEPF) begin
                    rd_v = mem_r[sel_r][fwb_r[sel_r]][fptr_r[sel_r][PW-1:0]];
                end
            end
            `UETC_A_CNT: rd_v = cnt_r[sel_r][fwb_r[sel_r]];
            `UETC_A_IEN: rd_v = 8'(ien_r);
            default: rd_v = 8'h00;
        endcase
    end

    // one wait cycle, then answer; unmapped reads give zero
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= {24'h00_0000, rd_v};
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sel_r <= EPW'(`UETC_SEL_RST);
            ien_r <= NUM_EP'(`UETC_IEN_RST);
        end else if (go_wr) begin
            if (avs_address == `UETC_A_SEL) begin
                sel_r <= wd[EPW-1:0];
            end
            if (avs_address == `UETC_A_IEN) begin
                ien_r <= wd[NUM_EP-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // token decision
    // ------------------------------------------------------------
    logic [EPW-1:0] tep;
    logic tgo;
    logic tin;
    logic tctl;
    logic tpp;
    logic tbank;
    logic tx_ok;
    logic dir_ok;
    uetc_kind_t tkind;

    always_comb begin
        tep = sie_rx.tok_ep[EPW-1:0];
        tkind = uetc_kind_t'(cfg_r[tep][`UETC_CFG_TY_HI:`UETC_CFG_TY_LO]);
        tctl = tkind == UETC_K_CTRL;
        tin = sie_rx.tok_kind == UETC_T_IN;
        // isochronous runs standard mode only
        tpp = cfg_r[tep][`UETC_CFG_PP] && cfg_r[tep][`UETC_CFG_TY_HI];
        tbank = tpp ? hwb_r[tep] : 1'b0;
        dir_ok = tctl || (tin == cfg_r[tep][`UETC_CFG_DIR]);
        tgo = sie_rx.tok_valid && st_r == UETC_S_IDLE && !usb_bus_reset
            && ({28'h000_0000, sie_rx.tok_ep} < 32'(NUM_EP))
            && cfg_r[tep][`UETC_CFG_EN] && dir_ok
            && (sie_rx.tok_kind != UETC_T_SETUP || tctl)
            && sie_rx.tok_kind != UETC_T_RSV;
        tx_ok = txr_r[tep][tbank];
    end

    logic rx_done;
    logic out_ok;
    logic setup_ok;
    logic iso_ok;
    logic in_ack;
    logic st_en;

    assign rx_done = st_r == UETC_S_RX && sie_rx.rx_end;
    assign out_ok = rx_done && sie_rx.rx_crc_ok && !drop_r && !iso_r && !stok_r;
    assign setup_ok = rx_done && sie_rx.rx_crc_ok && stok_r;
    assign iso_ok = rx_done && iso_r && !rxf_r[cur_ep_r][0];
    assign in_ack = st_r == UETC_S_WACK && sie_rx.host_ack;
    // iso bytes are kept only once the flag is free, so a late clear stores the tail
    assign st_en = st_r == UETC_S_RX && sie_rx.rx_valid && !drop_r
        && (!iso_r || !rxf_r[cur_ep_r][0]);

    // ------------------------------------------------------------
    // transaction sequencer
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st_r <= UETC_S_IDLE;
            cur_ep_r <= '0;
            cur_bank_r <= 1'b0;
            wptr_r <= 8'h00;
            tptr_r <= 8'h00;
            tlen_r <= 8'h00;
            drop_r <= 1'b0;
            iso_r <= 1'b0;
            stok_r <= 1'b0;
        end else if (usb_bus_reset) begin
            st_r <= UETC_S_IDLE;
        end else begin
            case (st_r)
                UETC_S_IDLE: begin
                    if (tgo) begin
                        cur_ep_r <= tep;
                        cur_bank_r <= tbank;
                        wptr_r <= 8'h00;
                        tptr_r <= 8'h00;
                        tlen_r <= cnt_r[tep][tbank];
                        iso_r <= tkind == UETC_K_ISO;
                        stok_r <= sie_rx.tok_kind == UETC_T_SETUP;
                        if (tin) begin
                            if (tx_ok) begin
                                st_r <= cnt_r[tep][tbank] == 8'h00 ? UETC_S_WACK : UETC_S_TX;
                            end
                        end else begin
                            st_r <= UETC_S_RX;
                            // setups are never refused
                            drop_r <= sie_rx.tok_kind != UETC_T_SETUP && tkind != UETC_K_ISO
                                && (rxf_r[tep][tbank] || setup_r[tep]);
                        end
                    end
                end
                UETC_S_RX: begin
                    // count what the host sent (iso: only the bytes kept), even past the fifo end
                    if (sie_rx.rx_valid && (!iso_r || st_en) && wptr_r != 8'hff) begin
                        wptr_r <= wptr_r + 8'h01;
                    end
                    if (sie_rx.rx_end) begin
                        st_r <= UETC_S_IDLE;
                    end
                end
                UETC_S_TX: begin
                    tptr_r <= tptr_r + 8'h01;
                    if (tptr_r == tlen_r - 8'h01) begin
                        st_r <= UETC_S_WACK;
                    end
                end
                UETC_S_WACK: begin
                    // timeout leaves ready set, so the next IN resends
                    if (sie_rx.host_ack || sie_rx.host_timeout) begin
                        st_r <= UETC_S_IDLE;
                    end
                end
                default: st_r <= UETC_S_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sie_tx <= '0;
        end else begin
            sie_tx.hs_valid <= 1'b0;
            sie_tx.tx_valid <= 1'b0;
            sie_tx.tx_last <= 1'b0;
            sie_tx.tx_zlp <= 1'b0;
            if (tgo && tin && !tx_ok) begin
                sie_tx.hs_valid <= 1'b1;
                sie_tx.hs_code <= UETC_H_NAK;
            end
            if (tgo && tin && tx_ok && cnt_r[tep][tbank] == 8'h00) begin
                sie_tx.tx_zlp <= 1'b1;
            end
            if (st_r == UETC_S_TX) begin
                sie_tx.tx_valid <= 1'b1;
                sie_tx.tx_data <= mem_r[cur_ep_r][cur_bank_r][tptr_r[PW-1:0]];
                sie_tx.tx_last <= tptr_r == tlen_r - 8'h01;
            end
            // isochronous OUT gets no handshake at all
            if (rx_done && sie_rx.rx_crc_ok && !iso_r) begin
                sie_tx.hs_valid <= 1'b1;
                sie_tx.hs_code <= drop_r ? UETC_H_NAK : UETC_H_ACK;
            end
        end
    end

    // ------------------------------------------------------------
    // per-endpoint state
    // ------------------------------------------------------------
    for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
        logic me;
        logic hw;
        logic ws;
        logic pp;
        logic c0;
        logic c1;
        logic tset;
        logic tcan;
        logic sclr;

        assign me = sel_r == EPW'(e);
        assign hw = cur_ep_r == EPW'(e);
        assign ws = w_sta && me;
        assign pp = cfg_r[e][`UETC_CFG_PP] && cfg_r[e][`UETC_CFG_TY_HI];
        assign c0 = ws && rxf_r[e][0] && !wd[`UETC_STA_RB0];
        assign c1 = ws && rxf_r[e][1] && !wd[`UETC_STA_RB1];
        assign tset = ws && wd[`UETC_STA_TXR] && !txr_r[e][fwb_r[e]];
        assign tcan = ws && !wd[`UETC_STA_TXR] && txr_r[e][0] && !pp;
        assign sclr = ws && setup_r[e] && !wd[`UETC_STA_SET];
        assign flag_v[e] = |rxf_r[e] || setup_r[e] || txc_r[e] || crc_r[e];

        always_ff @(posedge sys_clk or posedge reset) begin
            if (reset) begin
                cfg_r[e] <= `UETC_CFG_RST;
            end else if (usb_bus_reset) begin
                cfg_r[e] <= `UETC_CFG_RST;
            end else if (go_wr && avs_address == `UETC_A_CFG && me) begin
                cfg_r[e] <= wd;
            end
        end

        // status flags: a hardware set in the clearing cycle wins
        always_ff @(posedge sys_clk or posedge reset) begin
            if (reset) begin
                rxf_r[e] <= 2'b00;
                txr_r[e] <= 2'b00;
                setup_r[e] <= 1'b0;
                txc_r[e] <= 1'b0;
                crc_r[e] <= 1'b0;
                dir_r[e] <= 1'b0;
            end else if (usb_bus_reset) begin
                rxf_r[e] <= 2'b00;
                txr_r[e] <= 2'b00;
                setup_r[e] <= 1'b0;
                txc_r[e] <= 1'b0;
                crc_r[e] <= 1'b0;
                dir_r[e] <= 1'b0;
            end else if (hw && setup_ok) begin
                setup_r[e] <= 1'b1;
                rxf_r[e] <= 2'b00;
                txr_r[e] <= 2'b00;
                txc_r[e] <= 1'b0;
                crc_r[e] <= 1'b0;
                dir_r[e] <= 1'b0;
            end else begin
                if (c0) rxf_r[e][0] <= 1'b0;
                if (c1) rxf_r[e][1] <= 1'b0;
                if (hw && (out_ok || iso_ok)) begin
                    rxf_r[e][cur_bank_r] <= 1'b1;
                end
                if (sclr) setup_r[e] <= 1'b0;
                if (ws && !wd[`UETC_STA_TXC]) txc_r[e] <= 1'b0;
                if (hw && in_ack) txc_r[e] <= 1'b1;
                if (ws && !wd[`UETC_STA_CRC]) crc_r[e] <= 1'b0;
                if (hw && iso_ok) crc_r[e] <= !sie_rx.rx_crc_ok;
                if (ws) dir_r[e] <= wd[`UETC_STA_DIR];
                if (tset) txr_r[e][fwb_r[e]] <= 1'b1;
                if (tcan) txr_r[e][0] <= 1'b0;
                if (hw && in_ack) txr_r[e][cur_bank_r] <= 1'b0;
            end
        end

        always_ff @(posedge sys_clk or posedge reset) begin
            if (reset) begin
                fwb_r[e] <= 1'b0;
                hwb_r[e] <= 1'b0;
            end else if (usb_bus_reset) begin
                fwb_r[e] <= 1'b0;
                hwb_r[e] <= 1'b0;
            end else if (pp) begin
                if (c0 || c1) fwb_r[e] <= !fwb_r[e];
                if (tset) fwb_r[e] <= !fwb_r[e];
                if (hw && (out_ok || in_ack)) hwb_r[e] <= !hwb_r[e];
            end
        end

        always_ff @(posedge sys_clk or posedge reset) begin
            if (reset) begin
                cnt_r[e][0] <= `UETC_CNT_RST;
                cnt_r[e][1] <= `UETC_CNT_RST;
                fptr_r[e] <= '0;
            end else if (usb_bus_reset) begin
                cnt_r[e][0] <= `UETC_CNT_RST;
                cnt_r[e][1] <= `UETC_CNT_RST;
                fptr_r[e] <= '0;
            end else begin
                if (hw && (out_ok || iso_ok || setup_ok)) begin
                    cnt_r[e][cur_bank_r] <= wptr_r;
                end
                if (tset) cnt_r[e][fwb_r[e]] <= 8'(fptr_r[e]);
                if (tcan) cnt_r[e][0] <= `UETC_CNT_RST;
                if (c0 || c1 || tset || tcan || sclr) begin
                    fptr_r[e] <= '0;
                end else if (me && (f_wr || f_rd) && fptr_r[e] < DEPF) begin
                    fptr_r[e] <= fptr_r[e] + 1'b1;
                end
            end
        end

        // data only, no reset: contents are undefined until written
        always_ff @(posedge sys_clk) begin
            if (me && f_wr && fptr_r[e] < DEPF) begin
                mem_r[e][fwb_r[e]][fptr_r[e][PW-1:0]] <= wd;
            end
            if (hw && st_en && wptr_r < DEP8) begin
                mem_r[e][cur_bank_r][wptr_r[PW-1:0]] <= sie_rx.rx_data;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            usb_irq <= 1'b0;
        end else begin
            usb_irq <= |(ien_r & flag_v);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic irq_src;
    logic cur_pp;
    logic hwb_cur;
    assign irq_src = |(ien_r & flag_v);
    assign cur_pp = cfg_r[cur_ep_r][`UETC_CFG_PP] && cfg_r[cur_ep_r][`UETC_CFG_TY_HI];
    assign hwb_cur = hwb_r[cur_ep_r];

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    a_in_nak_std: assert property (tgo && tin && !tpp && !tx_ok
        |=> sie_tx.hs_valid && sie_tx.hs_code == UETC_H_NAK) else $error("IN not NAKed");
    a_in_nak_pp: assert property (tgo && tin && tpp && !txr_r[tep][tbank]
        |=> sie_tx.hs_valid && !sie_tx.tx_valid) else $error("ping-pong IN not NAKed");
    a_out_flag_set: assert property (out_ok && !usb_bus_reset
        |=> rxf_r[$past(cur_ep_r)][$past(cur_bank_r)]) else $error("received flag not set");
    a_bank_alt: assert property (out_ok && cur_pp && !usb_bus_reset
        |=> hwb_cur != $past(hwb_cur)) else $error("bank did not alternate");
    a_out_nak: assert property (rx_done && sie_rx.rx_crc_ok && drop_r && !iso_r
        |=> sie_tx.hs_valid && sie_tx.hs_code == UETC_H_NAK) else $error("full bank not NAKed");
    a_setup_wipe: assert property (setup_ok && !usb_bus_reset
        |=> setup_r[cur_ep_r] && rxf_r[cur_ep_r] == 2'b00 && !txc_r[cur_ep_r])
        else $error("setup did not clear status");
    a_ack_cmpl: assert property (in_ack && !usb_bus_reset
        |=> txc_r[cur_ep_r] && st_r == UETC_S_IDLE) else $error("complete flag missing");
    a_retry_hold: assert property (st_r == UETC_S_WACK && sie_rx.host_timeout
        && !sie_rx.host_ack && !usb_bus_reset && !w_sta
        |=> txr_r[cur_ep_r][cur_bank_r] && st_r == UETC_S_IDLE) else $error("retry lost");
    a_iso_silent: assert property (st_r == UETC_S_RX && iso_r
        |=> !sie_tx.hs_valid) else $error("handshake on isochronous");
    a_irq_level: assert property (##1 usb_irq == $past(irq_src))
        else $error("interrupt line wrong");
    a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer late");

    c_setup: cover property (setup_ok);
    c_pp_out: cover property (out_ok && cur_pp ##[1:200] out_ok && cur_pp);
    c_in_ack: cover property (in_ack);
    c_iso_tail: cover property (iso_ok && wptr_r != 8'h00);
endmodule : uetc_top

// File: design/uetc_defs.svh
// register offsets, field positions and reset values of the endpoint block
// Notes on behaviour
// - ping-pong OUT: valid packet in bank 0 sets its received flag, may interrupt
// - zero-length OUT reports byte count zero; firmware reads nothing then
// - firmware clearing a ping-pong received flag swaps the firmware bank
// - ping-pong OUT answers NAK only when the target bank is still unreleased
// - valid packet in bank 1 sets its flag; firmware drains before clearing
// - successive stored ping-pong OUT packets alternate between bank 0 and 1
// - bytes beyond fifo size are dropped, packet still valid on good crc
// - firmware loads fifo then sets transmit ready; empty fifo sends zero-length
// - standard IN with transmit ready clear answers every IN with NAK
// - standard mode: clearing transmit ready before sending discards the loaded packet
// - host acknowledge of IN sets transmit complete; firmware clears before refill
// - IN retries run in hardware until the host acknowledges
// - ping-pong IN: each transmit ready set switches the firmware bank
// - ping-pong IN: NAK when the addressed bank has no transmit ready
// - setup packet sets setup flag, clears all other status, may interrupt
// - control endpoint takes IN and OUT; firmware sets direction for IN data
// - status stage is zero-length IN for writes, zero-length OUT for reads
// - isochronous OUT crc error flag updated on every stored packet
// - isochronous OUT drops data silently while received flag is set
// - flag cleared mid-packet: only the remaining bytes are stored
// - per-endpoint registers act on the endpoint in the select register
// - endpoint kind: control 00, isochronous 01, bulk 10, interrupt 11
`ifndef UETC_DEFS_SVH
`define UETC_DEFS_SVH
`define UETC_A_SEL 8'h00
`define UETC_A_CFG 8'h04
`define UETC_A_STA 8'h08
`define UETC_A_FIFO 8'h0c
`define UETC_A_CNT 8'h10
`define UETC_A_IEN 8'h14
`define UETC_CFG_EN 7
`define UETC_CFG_PP 3
`define UETC_CFG_DIR 2
`define UETC_CFG_TY_HI 1
`define UETC_CFG_TY_LO 0
`define UETC_STA_TXC 0
`define UETC_STA_RB0 1
`define UETC_STA_SET 2
`define UETC_STA_CRC 3
`define UETC_STA_TXR 4
`define UETC_STA_RB1 6
`define UETC_STA_DIR 7
`define UETC_SEL_RST 8'h00
`define UETC_CFG_RST 8'h00
`define UETC_IEN_RST 8'h00
`define UETC_CNT_RST 8'h00
`endif

// File: design/uetc_pkg.sv
// types shared by the endpoint transaction block
package uetc_pkg;
    // endpoint kind encoding
    typedef enum logic [1:0] {
        UETC_K_CTRL = 2'b00, UETC_K_ISO = 2'b01, UETC_K_BULK = 2'b10, UETC_K_INTR = 2'b11
    } uetc_kind_t;
    typedef enum logic [1:0] {
        UETC_T_OUT = 2'b00, UETC_T_IN = 2'b01, UETC_T_SETUP = 2'b10, UETC_T_RSV = 2'b11
    } uetc_tok_t;
    typedef enum logic {UETC_H_ACK = 1'b0, UETC_H_NAK = 1'b1} uetc_hs_t;
    typedef enum logic [3:0] {
        UETC_S_IDLE = 4'b0001, UETC_S_RX = 4'b0010, UETC_S_TX = 4'b0100, UETC_S_WACK = 4'b1000
    } uetc_state_t;
    typedef struct packed {
        logic tok_valid;
        uetc_tok_t tok_kind;
        logic [3:0] tok_ep;
        logic rx_valid;
        logic [7:0] rx_data;
        logic rx_end;
        logic rx_crc_ok;
        logic host_ack;
        logic host_timeout;
    } uetc_sie_rx_t;
    typedef struct packed {
        logic hs_valid;
        uetc_hs_t hs_code;
        logic tx_valid;
        logic [7:0] tx_data;
        logic tx_last;
        logic tx_zlp;
    } uetc_sie_tx_t;
endpackage : uetc_pkg

// File: verif/uetc_host_model.sv
// host model: sends tokens and data packets, acks each IN packet unless miss is set, counts replies
`timescale 1ns/1ps
module uetc_host_model
    import uetc_pkg::*;
(
    input wire logic sys_clk,
    input wire uetc_sie_tx_t sie_tx,
    output uetc_sie_rx_t sie_rx
);
    int n_nak = 0, n_byte = 0, n_zlp = 0;
    bit miss = 1'b0;
    logic [7:0] last_tx;
    logic pk_end;
    assign pk_end = sie_tx.tx_zlp | (sie_tx.tx_valid & sie_tx.tx_last);
    initial sie_rx = '0;
    // acks at once; with miss set one packet times out so the block must resend it
    always @(posedge sys_clk) begin
        sie_rx.host_ack <= !miss & pk_end;
        sie_rx.host_timeout <= miss & pk_end;
        if (pk_end) miss <= 1'b0;
        if (sie_tx.tx_valid) last_tx <= sie_tx.tx_data;
        n_nak += int'(sie_tx.hs_valid & sie_tx.hs_code == UETC_H_NAK);
        n_byte += int'(sie_tx.tx_valid);
        n_zlp += int'(sie_tx.tx_zlp);
    end
    // n below zero: token only, as for IN
    task automatic xfer(input uetc_tok_t k, input logic [3:0] ep, input int n);
        @(posedge sys_clk);
        sie_rx.tok_valid <= 1'b1;
        sie_rx.tok_kind <= k;
        sie_rx.tok_ep <= ep;
        @(posedge sys_clk);
        sie_rx.tok_valid <= 1'b0;
        for (int i = 0; i < n; i++) begin
            sie_rx.rx_valid <= 1'b1;
            sie_rx.rx_data <= 8'ha0 + 8'(i);
            @(posedge sys_clk);
        end
        sie_rx.rx_valid <= 1'b0;
        sie_rx.rx_data <= ~sie_rx.rx_data;
        sie_rx.rx_end <= (n >= 0);
        sie_rx.rx_crc_ok <= 1'b1;
        @(posedge sys_clk);
        sie_rx.rx_end <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask : xfer
endmodule : uetc_host_model

// File: verif/usb_endpoint_transaction_ctrl_test.sv
// self-checking bench for the endpoint transaction controller
`timescale 1ns/1ps
`include "uetc_defs.svh"
module usb_endpoint_transaction_ctrl_test
    import uetc_pkg::*;
;
    logic sys_clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0, usb_irq;
    logic [7:0] avs_address = 8'h00, q;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic avs_waitrequest;
    uetc_sie_rx_t sie_rx;
    uetc_sie_tx_t sie_tx;
    int n_fail = 0, comparisons = 0, cyc = 0, b0;
    initial forever #2 sys_clk = ~sys_clk;
    uetc_top i_dut (.sys_clk(sys_clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'h1),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .usb_bus_reset(1'b0), .sie_rx(sie_rx),
        .sie_tx(sie_tx), .usb_irq(usb_irq));
    uetc_host_model i_host (.sys_clk(sys_clk), .sie_tx(sie_tx), .sie_rx(sie_rx));
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic chk(input string s, input logic [7:0] e);
        comparisons++;
        if (q !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, q);
        end
    endtask : chk
    task automatic rc(input logic [7:0] a, input string s, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(s, e);
    endtask : rc
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_in();
        bus(1'b1, `UETC_A_SEL, 8'h01);
        bus(1'b1, `UETC_A_CFG, 8'h86);
        bus(1'b1, `UETC_A_IEN, 8'h02);
        b0 = i_host.n_nak;
        i_host.xfer(UETC_T_IN, 4'h1, -1);
        q = 8'(i_host.n_nak - b0);
        chk("nak count", 8'h01);
        bus(1'b1, `UETC_A_FIFO, 8'h5a);
        bus(1'b1, `UETC_A_FIFO, 8'ha5);
        bus(1'b1, `UETC_A_STA, 8'h10);
        b0 = i_host.n_byte;
        i_host.xfer(UETC_T_IN, 4'h1, -1);
        q = 8'(i_host.n_byte - b0);
        chk("in bytes", 8'h02);
        q = i_host.last_tx;
        chk("in data", 8'ha5);
        rc(`UETC_A_STA, "tx complete", 8'h01);
        q = {7'h0, usb_irq};
        chk("irq", 8'h01);
        b0 = i_host.n_zlp;
        bus(1'b1, `UETC_A_STA, 8'h10);
        i_host.miss = 1'b1;
        i_host.xfer(UETC_T_IN, 4'h1, -1);
        q = 8'(i_host.n_zlp - b0);
        chk("zero length in", 8'h01);
        i_host.xfer(UETC_T_IN, 4'h1, -1);
        q = 8'(i_host.n_zlp - b0);
        chk("zero length retry", 8'h02);
        $display("test in done");
    endtask : test_in
    task automatic test_pp();
        bus(1'b1, `UETC_A_SEL, 8'h02);
        bus(1'b1, `UETC_A_CFG, 8'h8a);
        i_host.xfer(UETC_T_OUT, 4'h2, 3);
        rc(`UETC_A_STA, "bank0 flag", 8'h02);
        rc(`UETC_A_CNT, "count", 8'h03);
        i_host.xfer(UETC_T_OUT, 4'h2, 0);
        rc(`UETC_A_STA, "bank1 flag", 8'h42);
        b0 = i_host.n_nak;
        i_host.xfer(UETC_T_OUT, 4'h2, 2);
        q = 8'(i_host.n_nak - b0);
        chk("nak both full", 8'h01);
        bus(1'b1, `UETC_A_STA, 8'h40);
        rc(`UETC_A_STA, "swap", 8'h40);
        rc(`UETC_A_CNT, "zero length", 8'h00);
        $display("test ping-pong out done");
    endtask : test_pp
    task automatic test_setup();
        bus(1'b1, `UETC_A_SEL, 8'h00);
        bus(1'b1, `UETC_A_CFG, 8'h80);
        bus(1'b1, `UETC_A_STA, 8'h00);
        i_host.xfer(UETC_T_SETUP, 4'h0, 8);
        rc(`UETC_A_STA, "setup", 8'h04);
        rc(`UETC_A_FIFO, "setup byte", 8'ha0);
        rc(8'h3c, "unmapped", 8'h00);
        $display("test setup done");
    endtask : test_setup
    task automatic test_iso();
        bus(1'b1, `UETC_A_SEL, 8'h03);
        bus(1'b1, `UETC_A_CFG, 8'h81);
        b0 = i_host.n_nak;
        i_host.xfer(UETC_T_OUT, 4'h3, 2);
        rc(`UETC_A_STA, "iso flag", 8'h02);
        i_host.xfer(UETC_T_OUT, 4'h3, 3);
        rc(`UETC_A_CNT, "iso count", 8'h02);
        q = 8'(i_host.n_nak - b0);
        chk("iso no nak", 8'h00);
        $display("test isochronous out done");
    endtask : test_iso
    task automatic test_ppin();
        bus(1'b1, `UETC_A_SEL, 8'h01);
        bus(1'b1, `UETC_A_CFG, 8'h8e);
        b0 = i_host.n_nak;
        i_host.xfer(UETC_T_IN, 4'h1, -1);
        bus(1'b1, `UETC_A_FIFO, 8'h3c);
        bus(1'b1, `UETC_A_STA, 8'h10);
        rc(`UETC_A_STA, "bank switch", 8'h00);
        i_host.xfer(UETC_T_IN, 4'h1, -1);
        q = i_host.last_tx;
        chk("ping-pong data", 8'h3c);
        i_host.xfer(UETC_T_IN, 4'h1, -1);
        q = 8'(i_host.n_nak - b0);
        chk("ping-pong nak", 8'h02);
        $display("test ping-pong in done");
    endtask : test_ppin
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        test_in();
        test_pp();
        test_setup();
        test_iso();
        test_ppin();
        print_verdict();
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            print_verdict();
        end
    end
endmodule : usb_endpoint_transaction_ctrl_test
